// ### rtl/pxb_top.v
// Port crossbar: registers, routing and pin control
//
// How it works
// - enabled functions take the lowest free pin, in priority order.
// - serial port always on port 0 pins 4 and 5.
// - taken and skipped pins are passed over.
// - a skipped pin counts as taken.
// - skip bit n is pin n; 0x0c skips pins 2, 3.
// - analog pins lose pullup, driver and receiver.
// - input mode 1 digital, 0 analog; reset digital.
// - output mode bit picks the driver type, except on bus pins.
// - two-wire bus pins are always open drain.
// - pullup disable 0 pulls up open drain pins.
// - a pin driving low drops its pullup.
// - crossbar off: plain inputs, selects ignored.
// - drivers off while crossbar disabled.
// - port data write sets the latch.
// - latch 1 on open drain pin floats.
// - data read gives 1 for analog, else pin level.
`timescale 1ns/1ps
`include "pxb_regs.vh"

module pxb_top #(
    parameter NPIN = `PXB_NPIN,
    parameter NSLOT = `PXB_NSLOT
) (
    input wire SYS_CLK_IN, // System clock
    input wire RST_IN, // Async reset, high
    input wire [7:0] SFR_ADDR_IN, // Register address
    input wire [7:0] SFR_WDATA_IN, // Write data
    input wire SFR_WR_IN, // Write strobe
    input wire SFR_RD_IN, // Read strobe
    output reg [7:0] SFR_RDATA_OUT, // Read data
    output reg SFR_RVALID_OUT, // Read data valid
    input wire [NSLOT-1:0] FUNC_OUT_IN, // Function output values
    input wire [NSLOT-1:0] FUNC_OE_IN, // Function drive requests
    output reg [NSLOT-1:0] FUNC_LEVEL_OUT, // Pin level per function
    input wire [NPIN-1:0] PIN_LEVEL_IN, // Raw pin levels
    output wire [NPIN-1:0] PIN_DRIVE_OUT, // Pin drive values
    output wire [NPIN-1:0] PIN_OE_OUT, // Pin driver enables
    output wire [NPIN-1:0] PIN_PU_OUT // Weak pullup enables
);

    // ====
    // Storage
    reg [7:0] port_zero_data;
    reg [7:0] port_one_data;
    reg [7:0] port_zero_input_mode;
    reg [7:0] port_one_input_mode;
    reg [7:0] port_zero_output_mode;
    reg [7:0] port_one_output_mode;
    reg [7:0] port_zero_skip_mask;
    reg [7:0] port_one_skip_mask;
    reg [7:0] function_select_low;
    reg [7:0] function_select_high;

    // Routing state
    reg [NPIN-1:0] route_used;
    reg [NPIN*5-1:0] route_slot;
    wire [NPIN-1:0] next_used;
    wire [NPIN*5-1:0] next_slot;
    reg [NSLOT-1:0] slot_en;

    // Pin views
    wire [NPIN-1:0] pin_level;
    wire [NPIN-1:0] pin_digital;
    wire [NPIN-1:0] pin_pushpull;
    wire [NPIN-1:0] pin_latch;
    wire [NPIN-1:0] pin_skip;
    wire crossbar_enable;
    wire weak_pullup_disable;
    wire [2:0] cex_count;
    reg [7:0] next_rdata;
    reg next_rvalid;
    reg [NSLOT-1:0] next_func_level;
    integer s;
    integer f;
    integer q;

    // ====
    // Helpers

    // Data read view, analog reads high
    function [7:0] pxb_port_view;
        input [7:0] digital;
        input [7:0] level;
        begin
            pxb_port_view = level | ~digital;
        end
    endfunction

    // Pin carries one of the two-wire bus functions
    function pxb_is_bus;
        input [4:0] slot;
        begin
            pxb_is_bus = (slot == `PXB_SLOT_SDA) || (slot == `PXB_SLOT_SCL);
        end
    endfunction

    // ====
    // Field extraction
    assign crossbar_enable = function_select_high[`PXB_FH_CROSSBAR_ENABLE];
    assign weak_pullup_disable = function_select_high[`PXB_FH_WEAK_PULLUP_DISABLE];
    assign cex_count = function_select_high[`PXB_FH_CEX_MSB:`PXB_FH_CEX_LSB];

    // Port 0 in the low half
    assign pin_digital = {port_one_input_mode, port_zero_input_mode};
    assign pin_pushpull = {port_one_output_mode, port_zero_output_mode};
    assign pin_latch = {port_one_data, port_zero_data};
    assign pin_skip = {port_one_skip_mask, port_zero_skip_mask};

    // ====
    // Register writes
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            port_zero_data <= `PXB_RST_DATA;
            port_one_data <= `PXB_RST_DATA;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == `PXB_OFS_P0_DATA) begin
                port_zero_data <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == `PXB_OFS_P1_DATA) begin
                port_one_data <= SFR_WDATA_IN;
            end
        end
    end

    // Input modes, all digital after reset
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            port_zero_input_mode <= `PXB_RST_MDIN;
            port_one_input_mode <= `PXB_RST_MDIN;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == `PXB_OFS_P0_MDIN) begin
                port_zero_input_mode <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == `PXB_OFS_P1_MDIN) begin
                port_one_input_mode <= SFR_WDATA_IN;
            end
        end
    end

    // Output modes, open drain after reset
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            port_zero_output_mode <= `PXB_RST_MDOUT;
            port_one_output_mode <= `PXB_RST_MDOUT;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == `PXB_OFS_P0_MDOUT) begin
                port_zero_output_mode <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == `PXB_OFS_P1_MDOUT) begin
                port_one_output_mode <= SFR_WDATA_IN;
            end
        end
    end

    // Skip masks
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            port_zero_skip_mask <= `PXB_RST_SKIP;
            port_one_skip_mask <= `PXB_RST_SKIP;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == `PXB_OFS_P0_SKIP) begin
                port_zero_skip_mask <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == `PXB_OFS_P1_SKIP) begin
                port_one_skip_mask <= SFR_WDATA_IN;
            end
        end
    end

    // Function selects, crossbar off after reset
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            function_select_low <= `PXB_RST_FSEL;
            function_select_high <= `PXB_RST_FSEL;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == `PXB_OFS_FSEL_LO) begin
                function_select_low <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == `PXB_OFS_FSEL_HI) begin
                function_select_high <= SFR_WDATA_IN;
            end
        end
    end

    // ====
    // Register reads
    always @* begin
        next_rvalid = SFR_RD_IN;
        next_rdata = 8'h00;
        case (SFR_ADDR_IN)
            `PXB_OFS_P0_DATA: begin
                next_rdata = pxb_port_view(port_zero_input_mode, pin_level[7:0]);
            end
            `PXB_OFS_P1_DATA: begin
                next_rdata = pxb_port_view(port_one_input_mode, pin_level[15:8]);
            end
            `PXB_OFS_P0_MDIN: begin
                next_rdata = port_zero_input_mode;
            end
            `PXB_OFS_P1_MDIN: begin
                next_rdata = port_one_input_mode;
            end
            `PXB_OFS_P0_MDOUT: begin
                next_rdata = port_zero_output_mode;
            end
            `PXB_OFS_P1_MDOUT: begin
                next_rdata = port_one_output_mode;
            end
            `PXB_OFS_P0_SKIP: begin
                next_rdata = port_zero_skip_mask;
            end
            `PXB_OFS_P1_SKIP: begin
                next_rdata = port_one_skip_mask;
            end
            `PXB_OFS_FSEL_LO: begin
                next_rdata = function_select_low;
            end
            `PXB_OFS_FSEL_HI: begin
                next_rdata = function_select_high;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Read data holds until the next read
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SFR_RDATA_OUT <= 8'h00;
            SFR_RVALID_OUT <= 1'b0;
        end else begin
            SFR_RVALID_OUT <= next_rvalid;
            if (next_rvalid) begin
                SFR_RDATA_OUT <= next_rdata;
            end
        end
    end

    // ====
    // Select fields to slots
    always @* begin
        slot_en = {NSLOT{1'b0}};
        slot_en[`PXB_SLOT_TX] = function_select_low[`PXB_FL_UART];
        slot_en[`PXB_SLOT_RX] = function_select_low[`PXB_FL_UART];
        for (f = 0; f < 4; f = f + 1) begin
            slot_en[`PXB_SLOT_SPI + f] = function_select_low[`PXB_FL_SPI];
        end
        slot_en[`PXB_SLOT_SDA] = function_select_low[`PXB_FL_SMB];
        slot_en[`PXB_SLOT_SCL] = function_select_low[`PXB_FL_SMB];
        slot_en[`PXB_SLOT_SYSCLK] = function_select_low[`PXB_FL_SYSCLK];
        slot_en[`PXB_SLOT_CMP0] = function_select_low[`PXB_FL_CMP0];
        slot_en[`PXB_SLOT_CMP1] = function_select_low[`PXB_FL_CMP1];
        // Capture outputs enabled by count
        for (f = 0; f < 5; f = f + 1) begin
            slot_en[`PXB_SLOT_CEX + f] = (cex_count > f[2:0]);
        end
        slot_en[`PXB_SLOT_ECI] = function_select_high[`PXB_FH_ECI];
        slot_en[`PXB_SLOT_T0] = function_select_high[`PXB_FH_T0];
        slot_en[`PXB_SLOT_T1] = function_select_high[`PXB_FH_T1];
    end

    // ====
    // Priority walk
    pxb_assign #(
        .NPIN(NPIN),
        .NSLOT(NSLOT)
    ) u_assign (
        .slot_en_in(slot_en),
        .skip_in(pin_skip),
        .xbar_en_in(crossbar_enable),
        .used_out(next_used),
        .slot_out(next_slot)
    );

    // Routing flops
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            route_used <= {NPIN{1'b0}};
            route_slot <= {(NPIN*5){1'b0}};
        end else begin
            route_used <= next_used;
            route_slot <= next_slot;
        end
    end

    // ====
    // Pin level back to functions
    always @* begin
        next_func_level = {NSLOT{1'b1}};
        for (q = 0; q < NPIN; q = q + 1) begin
            for (s = 0; s < NSLOT; s = s + 1) begin
                if (route_used[q] && (route_slot[q*5 +: 5] == s[4:0])) begin
                    next_func_level[s] = pin_level[q];
                end
            end
        end
    end

    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FUNC_LEVEL_OUT <= {NSLOT{1'b1}};
        end else begin
            FUNC_LEVEL_OUT <= next_func_level;
        end
    end

    // ====
    // Pads
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pad
            wire [4:0] pslot;
            wire routed;
            assign pslot = route_slot[g*5 +: 5];
            assign routed = route_used[g];
            pxb_pad u_pad (
                .clk_in(SYS_CLK_IN),
                .rst_in(RST_IN),
                .digital_in(pin_digital[g]),
                .pushpull_in(pin_pushpull[g]),
                .force_od_in(routed & pxb_is_bus(pslot)),
                .weak_pud_in(weak_pullup_disable),
                .xbar_en_in(crossbar_enable),
                .routed_in(routed),
                .func_out_in(routed ? FUNC_OUT_IN[pslot] : 1'b1),
                .func_oe_in(routed ? FUNC_OE_IN[pslot] : 1'b0),
                .latch_in(pin_latch[g]),
                .pin_in(PIN_LEVEL_IN[g]),
                .pin_out(PIN_DRIVE_OUT[g]),
                .pin_oe_out(PIN_OE_OUT[g]),
                .pin_pu_out(PIN_PU_OUT[g]),
                .level_out(pin_level[g])
            );
        end
    endgenerate

endmodule

// ### inc/pxb_regs.vh
// Port crossbar register map and slot codes
`ifndef PXB_REGS_VH
`define PXB_REGS_VH

// ====
// Register offsets
`define PXB_OFS_P0_DATA 8'h80
`define PXB_OFS_P1_DATA 8'h90
`define PXB_OFS_P0_MDIN 8'hf1
`define PXB_OFS_P1_MDIN 8'hf2
`define PXB_OFS_P0_MDOUT 8'ha4
`define PXB_OFS_P1_MDOUT 8'ha5
`define PXB_OFS_P0_SKIP 8'hd4
`define PXB_OFS_P1_SKIP 8'hd5
`define PXB_OFS_FSEL_LO 8'he1
`define PXB_OFS_FSEL_HI 8'he2

// ====
// Reset values
`define PXB_RST_DATA 8'hff
`define PXB_RST_MDIN 8'hff
`define PXB_RST_MDOUT 8'h00
`define PXB_RST_SKIP 8'h00
`define PXB_RST_FSEL 8'h00

// ====
// Low function select fields
`define PXB_FL_UART 0
`define PXB_FL_SPI 1
`define PXB_FL_SMB 2
`define PXB_FL_SYSCLK 3
`define PXB_FL_CMP0 4
`define PXB_FL_CMP1 5

// ====
// High function select fields
`define PXB_FH_CEX_LSB 0
`define PXB_FH_CEX_MSB 2
`define PXB_FH_ECI 3
`define PXB_FH_T0 4
`define PXB_FH_T1 5
`define PXB_FH_CROSSBAR_ENABLE 6
`define PXB_FH_WEAK_PULLUP_DISABLE 7

// ====
// Function slots in priority order
`define PXB_SLOT_TX 0
`define PXB_SLOT_RX 1
`define PXB_SLOT_SPI 2
`define PXB_SLOT_SDA 6
`define PXB_SLOT_SCL 7
`define PXB_SLOT_SYSCLK 8
`define PXB_SLOT_CMP0 9
`define PXB_SLOT_CMP1 10
`define PXB_SLOT_CEX 11
`define PXB_SLOT_ECI 16
`define PXB_SLOT_T0 17
`define PXB_SLOT_T1 18
`define PXB_NSLOT 19
`define PXB_NPIN 16
`define PXB_UART_PIN_TX 4
`define PXB_UART_PIN_RX 5

`endif

// ### rtl/pxb_assign.v
// Priority walk that gives each enabled function slot a port pin while free pins remain
`timescale 1ns/1ps
`include "pxb_regs.vh"

module pxb_assign #(
    parameter NPIN = `PXB_NPIN,
    parameter NSLOT = `PXB_NSLOT
) (
    input wire [NSLOT-1:0] slot_en_in, // Enabled function slots
    input wire [NPIN-1:0] skip_in, // Skip masks, both ports
    input wire xbar_en_in, // Crossbar enable
    output reg [NPIN-1:0] used_out, // Pin carries a function
    output reg [NPIN*5-1:0] slot_out // Slot code per pin
);

    localparam [4:0] SLOT_TX = `PXB_SLOT_TX;
    localparam [4:0] SLOT_RX = `PXB_SLOT_RX;
    reg [NPIN-1:0] taken;
    reg found;
    integer k;
    integer p;

    // ====
    // Walk slots from highest priority downward
    always @* begin
        taken = skip_in;
        used_out = {NPIN{1'b0}};
        slot_out = {(NPIN*5){1'b0}};
        found = 1'b0;
        // Serial port pins are fixed, even if skipped
        if (slot_en_in[`PXB_SLOT_TX]) begin
            taken[`PXB_UART_PIN_TX] = 1'b1;
            taken[`PXB_UART_PIN_RX] = 1'b1;
            used_out[`PXB_UART_PIN_TX] = 1'b1;
            used_out[`PXB_UART_PIN_RX] = 1'b1;
            slot_out[`PXB_UART_PIN_TX*5 +: 5] = SLOT_TX;
            slot_out[`PXB_UART_PIN_RX*5 +: 5] = SLOT_RX;
        end
        for (k = `PXB_SLOT_SPI; k < NSLOT; k = k + 1) begin
            found = 1'b0;
            if (slot_en_in[k]) begin
                // Lowest free pin wins
                for (p = 0; p < NPIN; p = p + 1) begin
                    if (!found && !taken[p]) begin
                        taken[p] = 1'b1;
                        used_out[p] = 1'b1;
                        slot_out[p*5 +: 5] = k[4:0];
                        found = 1'b1;
                    end
                end
            end
        end
        // Disabled crossbar routes nothing
        if (!xbar_en_in) begin
            used_out = {NPIN{1'b0}};
        end
    end

endmodule

// ### rtl/pxb_pad.v
// One port pin: driver mode, weak pullup and input receiver
`timescale 1ns/1ps

module pxb_pad (
    input wire clk_in, // System clock
    input wire rst_in, // Async reset, high
    input wire digital_in, // 1 digital, 0 analog
    input wire pushpull_in, // Output mode bit
    input wire force_od_in, // Bus function forces open drain
    input wire weak_pud_in, // Global pullup disable
    input wire xbar_en_in, // Crossbar enable
    input wire routed_in, // Pin carries a function
    input wire func_out_in, // Function output value
    input wire func_oe_in, // Function wants to drive
    input wire latch_in, // Port data latch bit
    input wire pin_in, // Raw pin level
    output reg pin_out, // Pin drive value
    output reg pin_oe_out, // Pin driver enable
    output reg pin_pu_out, // Weak pullup on
    output wire level_out // Synced receiver level
);

    reg sync1;
    reg sync2;
    wire drive_val;
    wire want;
    wire pp;
    wire next_oe;
    wire next_pu;

    // ====
    // Drive decision
    assign drive_val = routed_in ? func_out_in : latch_in;
    assign want = routed_in ? func_oe_in : 1'b1;
    assign pp = pushpull_in & ~force_od_in;
    // Open drain never drives a one
    assign next_oe = xbar_en_in & digital_in & want & (pp | ~drive_val);
    // Pullup on open drain unless pulling low
    assign next_pu = digital_in & ~pp & ~weak_pud_in & ~(next_oe & ~drive_val);

    // Registered pad controls
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= 1'b1;
            pin_oe_out <= 1'b0;
            pin_pu_out <= 1'b0;
        end else begin
            pin_out <= drive_val;
            pin_oe_out <= next_oe;
            pin_pu_out <= next_pu;
        end
    end

    // ====
    // Two-flop receiver synchroniser
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
        end
    end

    // Analog pin receiver is off and reads high
    assign level_out = digital_in ? sync2 : 1'b1;

endmodule

// ### verif/pxb_monitor.sv
// Concurrent checks on the port crossbar top ports
`timescale 1ns/1ps
`include "pxb_regs.vh"

module pxb_monitor #(
    parameter NPIN = 16,
    parameter NSLOT = 19
) (
    input wire SYS_CLK_IN, // Clock
    input wire RST_IN, // Reset
    input wire [7:0] SFR_ADDR_IN, // Address
    input wire [7:0] SFR_WDATA_IN, // Write data
    input wire SFR_WR_IN, // Write
    input wire SFR_RD_IN, // Read
    input wire [7:0] SFR_RDATA_OUT, // Read data
    input wire SFR_RVALID_OUT, // Read valid
    input wire [NSLOT-1:0] FUNC_OUT_IN, // Function values
    input wire [NPIN-1:0] PIN_DRIVE_OUT, // Drive values
    input wire [NPIN-1:0] PIN_OE_OUT, // Driver enables
    input wire [NPIN-1:0] PIN_PU_OUT // Pullups
);
    // ====
    // Shadow registers
    reg [15:0] mdin;
    reg [15:0] mode;
    reg [7:0] lo;
    reg [7:0] hi;
    reg [1:0] quiet;
    reg mapped;

    // Shadow writes; quiet counts idle cycles
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mdin <= 16'hffff;
            mode <= 16'h0000;
            lo <= 8'h00;
            hi <= 8'h00;
            quiet <= 2'h0;
        end else begin
            if (SFR_WR_IN) begin
                case (SFR_ADDR_IN)
                    `PXB_OFS_P0_MDIN: mdin[7:0] <= SFR_WDATA_IN;
                    `PXB_OFS_P1_MDIN: mdin[15:8] <= SFR_WDATA_IN;
                    `PXB_OFS_P0_MDOUT: mode[7:0] <= SFR_WDATA_IN;
                    `PXB_OFS_P1_MDOUT: mode[15:8] <= SFR_WDATA_IN;
                    `PXB_OFS_FSEL_LO: lo <= SFR_WDATA_IN;
                    `PXB_OFS_FSEL_HI: hi <= SFR_WDATA_IN;
                    default: ;
                endcase
            end
            if (SFR_WR_IN)
                quiet <= 2'h0;
            else if (quiet != 2'h3)
                quiet <= quiet + 2'h1;
        end
    end

    // Mapped address decode
    always @* begin
        case (SFR_ADDR_IN)
            `PXB_OFS_P0_DATA, `PXB_OFS_P1_DATA, `PXB_OFS_P0_MDIN, `PXB_OFS_P1_MDIN,
            `PXB_OFS_P0_MDOUT, `PXB_OFS_P1_MDOUT, `PXB_OFS_P0_SKIP, `PXB_OFS_P1_SKIP,
            `PXB_OFS_FSEL_LO, `PXB_OFS_FSEL_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ====
    // Properties
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_bad_read;
        SFR_RD_IN && !mapped ##1 1'b1;
    endsequence

    a_read_valid_pulse: assert property (SFR_RVALID_OUT == $past(SFR_RD_IN))
        else $error("read valid late");
    a_unmapped_read_zero: assert property (s_bad_read |-> SFR_RVALID_OUT && SFR_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_off_no_drive: assert property (quiet == 2'h3 && !hi[6] |-> PIN_OE_OUT == 16'h0000)
        else $error("driver on with crossbar off");
    a_analog_pad_quiet: assert property (quiet == 2'h3 |-> ((PIN_OE_OUT | PIN_PU_OUT) & ~mdin) == 16'h0000)
        else $error("analog pin driven or pulled up");
    a_low_pullup_off: assert property ((PIN_OE_OUT & ~PIN_DRIVE_OUT & PIN_PU_OUT) == 16'h0000)
        else $error("pullup on while driving low");
    a_od_high_floats: assert property (quiet == 2'h3 |-> (PIN_OE_OUT & PIN_DRIVE_OUT & ~mode) == 16'h0000)
        else $error("open drain pin driven high");
    a_od_pullup_on: assert property (quiet == 2'h3 && !hi[7]
        |-> (mdin & ~mode & ~(PIN_OE_OUT & ~PIN_DRIVE_OUT) & ~PIN_PU_OUT) == 16'h0000)
        else $error("open drain pullup missing");
    a_serial_tx_pin: assert property (quiet == 2'h3 && hi[6] && lo[0]
        |-> PIN_DRIVE_OUT[4] == $past(FUNC_OUT_IN[0]))
        else $error("serial transmit not on pin 4");
endmodule

bind pxb_top pxb_monitor #(.NPIN(NPIN), .NSLOT(NSLOT)) pxb_monitor_i (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .SFR_ADDR_IN(SFR_ADDR_IN),
    .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN),
    .SFR_RDATA_OUT(SFR_RDATA_OUT), .SFR_RVALID_OUT(SFR_RVALID_OUT), .FUNC_OUT_IN(FUNC_OUT_IN),
    .PIN_DRIVE_OUT(PIN_DRIVE_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PIN_PU_OUT(PIN_PU_OUT));

// ### verif/pxb_pins.sv
// Pin-side model: outside circuits, weak pullups and floating pads
`timescale 1ns/1ps

module pxb_pins (
    input wire clk_in, // Clock
    input wire [15:0] drive_in, // Pad values
    input wire [15:0] oe_in, // Pad enables
    input wire [15:0] pu_in, // Pullups
    input wire [15:0] ext_en_in, // Outside drive on
    input wire [15:0] ext_val_in, // Outside value
    output wire [15:0] level_out // Pin levels
);
    reg [15:0] flt = 16'h5a5a;

    // A floating pad wanders every cycle
    always @(posedge clk_in)
        flt <= ~flt;

    // Pad, then outside circuit, then pullup
    assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
        | (~oe_in & ~ext_en_in & (pu_in | flt));
endmodule

// ### verif/testbench.sv
// Random and corner tests of the port crossbar
`timescale 1ns/1ps
`include "pxb_regs.vh"

module testbench;
    reg clk, rst, sfr_wr, sfr_rd;
    reg [7:0] addr, wdata, lo, hi;
    reg [18:0] fout, foe, fo, fe, e_flev;
    reg [15:0] ext_en, ext_val, xv, skip, mode, mdin, latch, e_drv, e_oe, e_pu, e_lvl, e_rd;
    reg [31:0] r0, r1, r2, r3, r4;
    reg [4:0] slot_of [0:15];
    wire [7:0] rdata;
    wire rvalid;
    wire [18:0] flev;
    wire [15:0] drv, oe, pu, lvl;
    integer failures, tests_run, seed, i, p, s;
    integer cycles = 0;

    pxb_top pxb_top_i (.SYS_CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr),
        .SFR_WDATA_IN(wdata), .SFR_WR_IN(sfr_wr), .SFR_RD_IN(sfr_rd), .SFR_RDATA_OUT(rdata),
        .SFR_RVALID_OUT(rvalid), .FUNC_OUT_IN(fout), .FUNC_OE_IN(foe), .FUNC_LEVEL_OUT(flev),
        .PIN_LEVEL_IN(lvl), .PIN_DRIVE_OUT(drv), .PIN_OE_OUT(oe), .PIN_PU_OUT(pu));
    pxb_pins pxb_pins_i (.clk_in(clk), .drive_in(drv), .oe_in(oe), .pu_in(pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

    // ====
    // Clock, hang guard and reporting
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            test_done;
        end
    end

    task test_done;
        begin
            if (failures == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task chk_pin(input [18:0] got, input [18:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, want);
            end
        end
    endtask

    task chk_reg(input [7:0] got, input [7:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, want);
            end
        end
    endtask

    // ====
    // Register bus cycles
    task reg_write(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            sfr_wr <= 1'b1;
            @(posedge clk);
            sfr_wr <= 1'b0;
        end
    endtask

    task reg_read(input [7:0] a, input [7:0] want);
        begin
            @(posedge clk);
            addr <= a;
            sfr_rd <= 1'b1;
            @(posedge clk);
            sfr_rd <= 1'b0;
            @(negedge clk);
            chk_reg({7'h00, rvalid}, 8'h01);
            chk_reg(rdata, want);
        end
    endtask

    // Expected routing walk and pad state for the current settings
    task model;
        reg [15:0] taken;
        reg [18:0] en;
        reg [4:0] sl;
        reg v, w, ppe;
        begin
            en = {hi[5], hi[4], hi[3], 5'h00, lo[5], lo[4], lo[3], {2{lo[2]}}, {4{lo[1]}}, {2{lo[0]}}};
            for (s = 0; s < 5; s = s + 1)
                en[11 + s] = (s < hi[2:0]);
            if (!hi[6])
                en = 19'h0;
            taken = skip;
            for (p = 0; p < 16; p = p + 1)
                slot_of[p] = 5'h1f;
            if (en[0]) begin
                slot_of[4] = 5'h00;
                slot_of[5] = 5'h01;
                taken[5:4] = 2'h3;
            end
            for (s = 2; s < 19; s = s + 1) begin
                p = 0;
                while (en[s] && p < 16 && taken[p])
                    p = p + 1;
                if (en[s] && p < 16) begin
                    slot_of[p] = s[4:0];
                    taken[p] = 1'b1;
                end
            end
            e_flev = 19'h7ffff;
            for (p = 0; p < 16; p = p + 1) begin
                sl = slot_of[p];
                v = (sl != 5'h1f) ? fo[sl] : latch[p];
                w = (sl != 5'h1f) ? fe[sl] : 1'b1;
                ppe = mode[p] & (sl != 5'h06) & (sl != 5'h07);
                e_drv[p] = v;
                e_oe[p] = hi[6] & mdin[p] & w & (ppe | !v);
                e_pu[p] = mdin[p] & !ppe & !hi[7] & !(e_oe[p] & !v);
                e_lvl[p] = e_oe[p] ? v : xv[p];
                if (sl != 5'h1f)
                    e_flev[sl] = mdin[p] ? e_lvl[p] : 1'b1;
            end
            e_rd = ~mdin | e_lvl;
        end
    endtask

    // ====
    // Main sequence
    initial begin
        seed = 32'h9c9f;
        failures = 0;
        tests_run = 0;
        rst = 1'b1;
        {sfr_wr, sfr_rd, addr, wdata, fout, foe, ext_en, ext_val} = 88'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk_pin({3'h0, pu}, 19'h0ffff);
        chk_pin({3'h0, oe}, 19'h00000);
        reg_read(`PXB_OFS_P0_DATA, 8'hff);
        reg_read(8'h00, 8'h00);
        for (i = 0; i < 40; i = i + 1) begin
            r0 = $random(seed);
            r1 = $random(seed);
            r2 = $random(seed);
            r3 = $random(seed);
            r4 = $random(seed);
            {lo, hi, skip} = {r0[7:0], r0[15:8] | 8'h40, r0[31:16]};
            {mode, mdin, latch} = {r1[15:0], r1[31:16] | r2[15:0], r2[31:16]};
            {fo, fe, xv} = {r3[18:0], r4[18:0], r4[31:16]};
            skip = skip | ~mdin;
            if (i % 2 == 1)
                skip[15:14] = 2'h3;
            if (i == 0)
                {lo, hi, skip, mdin} = {8'h01, 8'h45, 16'h000c, 16'hffff};
            if (i == 1)
                hi = 8'h3f;
            if (i == 2)
                {lo, hi, skip, mdin} = {8'h3e, 8'h7d, 16'h0000, 16'hffff};
            if (i == 3)
                {mdin, skip} = {16'h0000, 16'hffff};
            model;
            @(posedge clk);
            fout <= fo;
            foe <= fe;
            ext_val <= xv;
            ext_en <= ~e_oe;
            reg_write(`PXB_OFS_P0_DATA, latch[7:0]);
            reg_write(`PXB_OFS_P1_DATA, latch[15:8]);
            reg_write(`PXB_OFS_P0_MDIN, mdin[7:0]);
            reg_write(`PXB_OFS_P1_MDIN, mdin[15:8]);
            reg_write(`PXB_OFS_P0_MDOUT, mode[7:0]);
            reg_write(`PXB_OFS_P1_MDOUT, mode[15:8]);
            reg_write(`PXB_OFS_P0_SKIP, skip[7:0]);
            reg_write(`PXB_OFS_P1_SKIP, skip[15:8]);
            reg_write(`PXB_OFS_FSEL_LO, lo);
            reg_write(`PXB_OFS_FSEL_HI, hi);
            repeat (5) @(posedge clk);
            @(negedge clk);
            chk_pin({3'h0, drv}, {3'h0, e_drv});
            chk_pin({3'h0, oe}, {3'h0, e_oe});
            chk_pin({3'h0, pu}, {3'h0, e_pu});
            chk_pin(flev, e_flev);
            reg_read(`PXB_OFS_P0_DATA, e_rd[7:0]);
        end
        test_done;
    end
endmodule
